/* File: design/asp_top.sv */
// Purpose: Asynchronous serial port, transmit and receive
// Assumes: Configuration is held stable while either path runs
// Notes: Illegal frame combinations are forced to legal ones
`timescale 1ns/1ps
module asp_top #(
	parameter int unsigned FIFO_DEPTH = 32
) (
	input  wire logic              MCLK,
	input  wire logic              RST,
	input  wire asp_pkg::asp_cfg_t CFG,
	input  wire logic              TX_RUN,
	input  wire logic              RX_RUN,
	input  wire logic [7:0]        TX_DATA,
	input  wire logic              TX_NINTH,
	input  wire logic              TX_VALID,
	output logic                   TX_READY,
	output logic [7:0]             RX_DATA,
	input  wire logic              RX_READ,
	input  wire logic [4:0]        IRQ_EN,
	input  wire logic [7:0]        STAT_CLR,
	output asp_pkg::asp_stat_t     STATUS,
	output logic                   IRQ,
	input  wire logic              RXD,
	output logic                   TXD
);
	logic [asp_pkg::ASP_DIV_W-1:0] div_q;
	logic                          tick_q;
	logic                          nine;
	logic [1:0]                    par;
	logic                          two;
	logic [8:0]                    fin_data;
	logic                          fin_ready;
	logic [8:0]                    fo_data;
	logic                          fo_valid;
	logic                          fo_take;
	asp_pkg::asp_state_t           ts_q;
	logic [3:0]                    tov_q;
	logic [3:0]                    tbit_q;
	logic [8:0]                    tsh_q;
	logic                          tpar_q;
	logic                          tstop2_q;
	logic                          ev_txe;
	logic                          ev_txc;
	logic [1:0]                    rsync_q;
	logic                          rxi;
	asp_pkg::asp_state_t           rs_q;
	logic [3:0]                    rov_q;
	logic [3:0]                    rbit_q;
	logic [8:0]                    rsh_q;
	logic [1:0]                    smp_q;
	logic [2:0]                    smp;
	logic                          rpar_q;
	logic                          maj;
	logic                          ev_rxf;
	logic                          ev_ovr;
	logic                          ev_fe;
	logic                          ev_ne;
	logic                          ev_brk;
	logic                          unread_q;
	logic [7:0]                    brk_q;
	logic                          brk_done_q;
	asp_pkg::asp_stat_t            st_d;

	initial begin
		if (FIFO_DEPTH < 2) $error("FIFO depth too small");
	end

	// Frame option exclusion
	assign nine = CFG.nine && CFG.par == asp_pkg::ASP_PAR_NONE && !CFG.two_stop; // see RULE_03
	assign par  = (CFG.par == asp_pkg::ASP_PAR_EVEN || CFG.par == asp_pkg::ASP_PAR_ODD)
		? CFG.par : asp_pkg::ASP_PAR_NONE; // see RULE_04
	assign two  = CFG.two_stop && par == asp_pkg::ASP_PAR_NONE; // see RULE_05, RULE_06

	// Oversample tick for the chosen rate; 100 MHz divides all rates exactly enough
	always_ff @(posedge MCLK) begin
		if (RST) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == '0) begin
			div_q  <= asp_pkg::asp_div(CFG.baud); // see RULE_01, RULE_14
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q - 1'b1;
			tick_q <= 1'b0;
		end
	end

	assign fin_data = {TX_NINTH, TX_DATA}; // see RULE_15
	always_ff @(posedge MCLK) begin
		if (RST) begin
			TX_READY <= 1'b0;
		end else begin
			TX_READY <= fin_ready && !(TX_VALID && TX_READY);
		end
	end

	asp_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
		.MCLK      (MCLK),
		.RST       (RST),
		.in_data   (fin_data),
		.in_valid  (TX_VALID && TX_READY),
		.in_ready  (fin_ready),
		.out_data  (fo_data),
		.out_valid (fo_valid),
		.out_ready (fo_take)
	);

	// Transmitter
	assign fo_take = ts_q == asp_pkg::ASP_IDLE && fo_valid && TX_RUN && tick_q; // see RULE_16
	assign ev_txe  = fo_take; // see RULE_07
	assign ev_txc  = ts_q == asp_pkg::ASP_STOP && tick_q && tov_q == asp_pkg::ASP_LAST
		&& (!tstop2_q) && !fo_valid; // see RULE_08
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ts_q     <= asp_pkg::ASP_IDLE;
			tov_q    <= '0;
			tbit_q   <= '0;
			tsh_q    <= '0;
			tpar_q   <= 1'b0;
			tstop2_q <= 1'b0;
			TXD      <= 1'b1;
		end else if (fo_take) begin
			ts_q   <= asp_pkg::ASP_START;
			tsh_q  <= nine ? fo_data : {1'b0, fo_data[7:0]};
			tpar_q <= (^fo_data[7:0]) ^ (par == asp_pkg::ASP_PAR_ODD); // see RULE_04
			tov_q  <= '0;
			TXD    <= 1'b0; // see RULE_17
		end else if (tick_q && ts_q != asp_pkg::ASP_IDLE) begin
			tov_q <= tov_q + 1'b1;
			if (tov_q == asp_pkg::ASP_LAST) begin
				case (ts_q)
					asp_pkg::ASP_START: begin
						ts_q   <= asp_pkg::ASP_DATA;
						tbit_q <= '0;
						TXD    <= tsh_q[0]; // see RULE_17
						tsh_q  <= tsh_q >> 1;
					end
					asp_pkg::ASP_DATA: begin
						if (tbit_q == (nine ? 4'h8 : 4'h7)) begin // see RULE_02
							if (par != asp_pkg::ASP_PAR_NONE) begin
								ts_q <= asp_pkg::ASP_PAR;
								TXD  <= tpar_q;
							end else begin
								ts_q     <= asp_pkg::ASP_STOP;
								tstop2_q <= two; // see RULE_06
								TXD      <= 1'b1;
							end
						end else begin
							tbit_q <= tbit_q + 1'b1;
							TXD    <= tsh_q[0];
							tsh_q  <= tsh_q >> 1;
						end
					end
					asp_pkg::ASP_PAR: begin
						ts_q     <= asp_pkg::ASP_STOP;
						tstop2_q <= 1'b0;
						TXD      <= 1'b1;
					end
					default: begin
						if (tstop2_q) begin
							tstop2_q <= 1'b0;
						end else begin
							ts_q <= asp_pkg::ASP_IDLE;
						end
						TXD <= 1'b1;
					end
				endcase
			end
		end
	end

	// Receiver input synchroniser
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rsync_q <= 2'h3;
		end else begin
			rsync_q <= {rsync_q[0], RXD};
		end
	end
	assign rxi = rsync_q[1];
	// Samples of ticks 6 and 7 with the live sample of tick 8
	assign smp = {smp_q, rxi};
	assign maj = (smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]);

	assign ev_rxf = rs_q == asp_pkg::ASP_STOP && tick_q && rov_q == asp_pkg::ASP_S2; // see RULE_09
	assign ev_ovr = ev_rxf && unread_q; // see RULE_10
	assign ev_fe  = ev_rxf && !maj; // see RULE_18
	assign ev_ne  = rs_q != asp_pkg::ASP_IDLE && tick_q && rov_q == asp_pkg::ASP_S2
		&& !(smp == 3'h0 || smp == 3'h7); // see RULE_18

	always_ff @(posedge MCLK) begin
		if (RST) begin
			rs_q   <= asp_pkg::ASP_IDLE;
			rov_q  <= '0;
			rbit_q <= '0;
			rsh_q  <= '0;
			smp_q  <= 2'h3;
			rpar_q <= 1'b0;
		end else if (!RX_RUN) begin
			rs_q <= asp_pkg::ASP_IDLE; // see RULE_16
		end else if (tick_q) begin
			rov_q <= rov_q + 1'b1;
			if (rov_q >= asp_pkg::ASP_S0 && rov_q <= asp_pkg::ASP_S2) begin
				smp_q <= {smp_q[0], rxi};
			end
			case (rs_q)
				asp_pkg::ASP_IDLE: begin
					rov_q <= '0;
					if (!rxi) begin
						rs_q <= asp_pkg::ASP_START;
					end
				end
				asp_pkg::ASP_START: begin
					if (rov_q == asp_pkg::ASP_S2 && maj) begin
						rs_q <= asp_pkg::ASP_IDLE;
					end else if (rov_q == asp_pkg::ASP_LAST) begin
						rs_q   <= asp_pkg::ASP_DATA;
						rbit_q <= '0;
					end
				end
				asp_pkg::ASP_DATA: begin
					if (rov_q == asp_pkg::ASP_S2) begin
						rsh_q <= nine ? {maj, rsh_q[8:1]} : {1'b0, maj, rsh_q[7:1]};
					end
					if (rov_q == asp_pkg::ASP_LAST) begin
						if (rbit_q == (nine ? 4'h8 : 4'h7)) begin
							rs_q <= par != asp_pkg::ASP_PAR_NONE
								? asp_pkg::ASP_PAR : asp_pkg::ASP_STOP;
						end else begin
							rbit_q <= rbit_q + 1'b1;
						end
					end
				end
				asp_pkg::ASP_PAR: begin
					if (rov_q == asp_pkg::ASP_S2) begin
						rpar_q <= maj;
					end
					if (rov_q == asp_pkg::ASP_LAST) begin
						rs_q <= asp_pkg::ASP_STOP;
					end
				end
				default: begin
					if (rov_q == asp_pkg::ASP_S2) begin
						rs_q <= asp_pkg::ASP_IDLE;
					end
				end
			endcase
		end
	end

	// Break: ten bit times of continuous low
	always_ff @(posedge MCLK) begin
		if (RST) begin
			brk_q      <= '0;
			brk_done_q <= 1'b0;
		end else if (rxi) begin
			brk_q      <= '0;
			brk_done_q <= 1'b0;
		end else if (tick_q && !brk_done_q) begin
			brk_q <= brk_q + 1'b1;
			if (brk_q == 8'(asp_pkg::ASP_BRK_BITS * asp_pkg::ASP_OVS - 1)) begin
				brk_done_q <= 1'b1;
			end
		end
	end
	assign ev_brk = tick_q && !rxi && !brk_done_q
		&& brk_q == 8'(asp_pkg::ASP_BRK_BITS * asp_pkg::ASP_OVS - 1); // see RULE_11

	// Receive buffer
	always_ff @(posedge MCLK) begin
		if (RST) begin
			RX_DATA  <= '0;
			unread_q <= 1'b0;
		end else if (ev_rxf) begin
			RX_DATA  <= rsh_q[7:0];
			unread_q <= 1'b1;
		end else if (RX_READ) begin
			unread_q <= 1'b0;
		end
	end

	// Sticky status; a set wins over a clear in the same cycle; ninth is reloaded with each received word and STAT_CLR does not clear it
	always_comb begin
		st_d            = STATUS & ~STAT_CLR;
		st_d.tx_empty   = st_d.tx_empty | ev_txe;
		st_d.tx_done    = st_d.tx_done | ev_txc;
		st_d.rx_full    = st_d.rx_full | ev_rxf;
		st_d.overrun    = st_d.overrun | ev_ovr;
		st_d.line_break = st_d.line_break | ev_brk;
		st_d.frame_err  = st_d.frame_err | ev_fe
			| (ev_rxf && par != asp_pkg::ASP_PAR_NONE
			&& (rpar_q != ((^rsh_q[7:0]) ^ (par == asp_pkg::ASP_PAR_ODD))));
		st_d.noise_err  = st_d.noise_err | ev_ne;
		st_d.ninth      = ev_rxf ? (nine & rsh_q[8]) : STATUS.ninth;
	end
	always_ff @(posedge MCLK) begin
		if (RST) begin
			STATUS <= '0;
			IRQ    <= 1'b0;
		end else begin
			STATUS <= st_d; // see RULE_13
			IRQ    <= |(st_d[4:0] & IRQ_EN); // see RULE_12
		end
	end

	AST_TX_IDLE_HIGH: assert property (@(posedge MCLK) disable iff (RST)
		(ts_q == asp_pkg::ASP_IDLE && !$past(fo_take)) |-> TXD) // see RULE_17
		else $error("TXD low while idle");
	AST_NINE_EXCL: assert property (@(posedge MCLK) disable iff (RST)
		nine |-> (par == asp_pkg::ASP_PAR_NONE && !two)) // see RULE_03
		else $error("nine bits combined with parity or two stops");
	AST_PAR_ONE_STOP: assert property (@(posedge MCLK) disable iff (RST)
		(par != asp_pkg::ASP_PAR_NONE) |-> !two && !nine) // see RULE_05
		else $error("parity with two stops");
	AST_TXE_SET: assert property (@(posedge MCLK) disable iff (RST)
		ev_txe |=> STATUS.tx_empty) // see RULE_07
		else $error("tx empty not flagged");
	AST_TXC_SET: assert property (@(posedge MCLK) disable iff (RST)
		ev_txc |=> STATUS.tx_done && ts_q == asp_pkg::ASP_IDLE) // see RULE_08
		else $error("tx done not flagged");
	AST_RXF_DATA: assert property (@(posedge MCLK) disable iff (RST)
		ev_rxf |=> STATUS.rx_full && unread_q && RX_DATA == $past(rsh_q[7:0])) // see RULE_09
		else $error("rx word not buffered");
	AST_OVR: assert property (@(posedge MCLK) disable iff (RST)
		(ev_rxf && unread_q) |=> STATUS.overrun) // see RULE_10
		else $error("overrun missed");
	AST_IRQ: assert property (@(posedge MCLK) disable iff (RST)
		IRQ == |(STATUS[4:0] & $past(IRQ_EN))) // see RULE_12
		else $error("irq mismatch");
	AST_TICK_PERIOD: assert property (@(posedge MCLK) disable iff (RST)
		tick_q |=> !tick_q [*8]) // see RULE_01
		else $error("tick too fast");
endmodule

/* File: design/asp_pkg.sv */
// Purpose: Constants and types for the asynchronous serial port
// Assumes: MCLK at 100 MHz, baud timing from a 16x oversample tick
// Notes: Baud divisors, frame state codes and carrier structs
// Operation
// RULE_01: Bit timing at 600, 1200, 2400, 4800, 9600 or 38400 baud only.
// RULE_02: Data field length is eight or nine bits.
// RULE_03: Nine data bits never combine with parity or two stop bits.
// RULE_04: Parity none, odd or even; generated on transmit, checked on receive.
// RULE_05: With parity, only one stop bit and eight data bits.
// RULE_06: One or two stop bits; two only without parity, eight bits.
// RULE_07: Transmit empty flags when holding word moves into shift register.
// RULE_08: Transmit complete flags after last stop bit with nothing pending.
// RULE_09: Receive full flags when received word lands in receive buffer.
// RULE_10: Overrun flags when frame ends while previous word is unread.
// RULE_11: Line break flags when line stays low ten bit times.
// RULE_12: Five events each enabled, all sharing one interrupt request.
// RULE_13: Status word holds all flags plus framing, noise and ninth bit.
// RULE_14: Correct timing only for 5, 10 or 20 MHz device clock; the divisors here assume a 100 MHz MCLK.
// RULE_15: Nine-bit frames send a software-supplied ninth bit.
// RULE_16: Transmit and receive paths start and stop independently.
// RULE_17: Frame is idle high, start low, LSB first, parity, high stops.
// RULE_18: Framing error on low stop; noise error on sample disagreement.
package asp_pkg;
	localparam int unsigned ASP_CLK_HZ   = 100000000;
	localparam int unsigned ASP_OVS      = 16;
	localparam int unsigned ASP_DIV_W    = 16;
	localparam int unsigned ASP_BRK_BITS = 10;
	localparam logic [2:0]  ASP_B600   = 3'h0;
	localparam logic [2:0]  ASP_B1200  = 3'h1;
	localparam logic [2:0]  ASP_B2400  = 3'h2;
	localparam logic [2:0]  ASP_B4800  = 3'h3;
	localparam logic [2:0]  ASP_B9600  = 3'h4;
	localparam logic [2:0]  ASP_B38400 = 3'h5;
	localparam logic [1:0]  ASP_PAR_NONE = 2'h0;
	localparam logic [1:0]  ASP_PAR_ODD  = 2'h1;
	localparam logic [1:0]  ASP_PAR_EVEN = 2'h2;
	localparam logic [3:0]  ASP_MID = 4'h7;
	localparam logic [3:0]  ASP_S0  = 4'h6;
	localparam logic [3:0]  ASP_S2  = 4'h8;
	localparam logic [3:0]  ASP_LAST = 4'hF;
	function automatic logic [ASP_DIV_W-1:0] asp_div(input logic [2:0] sel);
		int unsigned baud;
		baud = 9600;
		case (sel)
			ASP_B600:   baud = 600;
			ASP_B1200:  baud = 1200;
			ASP_B2400:  baud = 2400;
			ASP_B4800:  baud = 4800;
			ASP_B38400: baud = 38400;
			default:    baud = 9600;
		endcase
		return ASP_DIV_W'((ASP_CLK_HZ / (baud * ASP_OVS)) - 1);
	endfunction
	typedef enum logic [2:0] {
		ASP_IDLE = 3'h0,
		ASP_START = 3'h1,
		ASP_DATA = 3'h3,
		ASP_PAR = 3'h2,
		ASP_STOP = 3'h6
	} asp_state_t;
	typedef struct packed {
		logic [2:0] baud;
		logic       nine;
		logic [1:0] par;
		logic       two_stop;
	} asp_cfg_t;
	typedef struct packed {
		logic ninth;
		logic noise_err;
		logic frame_err;
		logic line_break;
		logic overrun;
		logic rx_full;
		logic tx_done;
		logic tx_empty;
	} asp_stat_t;
endpackage

/* File: design/asp_fifo.sv */
// Purpose: Synchronous FIFO for transmit words
// Assumes: Single clock, synchronous active high reset
// Notes: Full and empty are exact
`timescale 1ns/1ps
module asp_fifo #(
	parameter int unsigned W = 9,
	parameter int unsigned D = 32
) (
	input  wire logic         MCLK,
	input  wire logic         RST,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int unsigned AW = $clog2(D);
	initial begin
		if (D < 2 || (1 << AW) != D) $error("FIFO depth must be a power of two");
	end
	logic [W-1:0] mem [D];
	logic [AW:0]  wp_q;
	logic [AW:0]  rp_q;
	logic         wr;
	logic         rd;
	assign in_ready  = (wp_q - rp_q) != (AW+1)'(D);
	assign out_valid = wp_q != rp_q;
	assign out_data  = mem[rp_q[AW-1:0]];
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;
	always_ff @(posedge MCLK) begin
		if (wr) begin
			mem[wp_q[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge MCLK) begin
		if (RST) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (wr) begin
				wp_q <= wp_q + 1'b1;
			end
			if (rd) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule

/* File: tb/asp_peer.sv */
// Purpose: Remote serial peer for the serial port bench
// Assumes: 38400 baud at MCLK 100 MHz, ten bits after start on TXD
// Notes: Sends frames on RXD and captures TXD frames into a queue
`timescale 1ns/1ps
module asp_peer #(
	parameter int BIT = 2592
) (
	input  wire logic MCLK,
	input  wire logic TXD,
	output logic      RXD
);
	logic [10:0] cap_q[$];
	logic [10:0] cap;
	// Line idles high between frames
	initial begin
		RXD = 1'b1;
	end
	// Start low, bits LSB first, caller supplies parity and stop levels
	task automatic send(input logic [9:0] bits);
		RXD = 1'b0;
		repeat (BIT) @(negedge MCLK);
		for (int i = 0; i < 10; i++) begin
			RXD = bits[i];
			repeat (BIT) @(negedge MCLK);
		end
		RXD = 1'b1;
	endtask
	// Holds the line low for a break
	task automatic hold_low(input int n);
		RXD = 1'b0;
		repeat (n) @(negedge MCLK);
		RXD = 1'b1;
	endtask
	// Samples start and ten further bits at mid-bit
	always begin
		@(negedge TXD);
		repeat (BIT / 2) @(posedge MCLK);
		for (int i = 0; i < 11; i++) begin
			cap[i] = TXD;
			if (i < 10) repeat (BIT) @(posedge MCLK);
		end
		cap_q.push_back(cap);
	end
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the serial port
// Assumes: 38400 baud, inputs driven at the falling edge
// Notes: Transmit frames are judged by the peer's captures
`timescale 1ns/1ps
module testbench;
	localparam int BIT = 16 * (100000000 / (38400 * 16));
	logic               mclk, rst, tx_run, rx_run, tx_ninth, tx_valid;
	logic               tx_ready, rx_read, rxd, txd, irq, low;
	logic [7:0]         tx_data, rx_data, stat_clr;
	logic [4:0]         irq_en;
	asp_pkg::asp_cfg_t  cfg;
	asp_pkg::asp_stat_t status;
	int                 failures, checks_done;
	asp_top uut (.MCLK(mclk), .RST(rst), .CFG(cfg), .TX_RUN(tx_run), .RX_RUN(rx_run),
		.TX_DATA(tx_data), .TX_NINTH(tx_ninth), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.RX_DATA(rx_data), .RX_READ(rx_read), .IRQ_EN(irq_en), .STAT_CLR(stat_clr),
		.STATUS(status), .IRQ(irq), .RXD(rxd), .TXD(txd));
	asp_peer #(.BIT(BIT)) peer (.MCLK(mclk), .TXD(txd), .RXD(rxd));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic conclude;
		if (failures == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic put(input logic [7:0] d, input logic n);
		int k;
		@(negedge mclk);
		tx_data = d;
		tx_ninth = n;
		tx_valid = 1'b1;
		k = 0;
		while (tx_ready !== 1'b1 && k < 200) begin
			@(negedge mclk);
			k++;
		end
		chk("tx_ready", 11'h001, 11'(tx_ready));
		@(negedge mclk);
		tx_valid = 1'b0;
	endtask
	task automatic wait_caps(input int n);
		int k;
		k = 0;
		while (peer.cap_q.size() < n && k < 40000) begin
			@(negedge mclk);
			k++;
		end
		chk("frames", 11'(n), 11'(peer.cap_q.size()));
	endtask
	task automatic set_cfg(input logic n, input logic [1:0] p);
		tx_run = 1'b0;
		rx_run = 1'b0;
		cfg = '{asp_pkg::ASP_B38400, n, p, 1'b0};
		@(negedge mclk);
	endtask
	initial begin
		repeat (150000) @(posedge mclk);
		failures++;
		conclude();
	end
	initial begin
		failures = 0;
		checks_done = 0;
		rst = 1'b1;
		tx_run = 1'b0;
		rx_run = 1'b0;
		tx_data = 8'h00;
		tx_ninth = 1'b0;
		tx_valid = 1'b0;
		rx_read = 1'b0;
		irq_en = 5'h04;
		stat_clr = 8'h00;
		low = 1'b0;
		cfg = '{asp_pkg::ASP_B38400, 1'b0, asp_pkg::ASP_PAR_EVEN, 1'b0};
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		tx_run = 1'b1;
		rx_run = 1'b1;
		chk("status", 11'h000, 11'(status));
		chk("txd", 11'h001, 11'(txd));
		fork
			begin
				put(8'hA7, 1'b0);
				put(8'h3C, 1'b0);
			end
			begin
				peer.send({1'b1, 1'b1, 8'h97});
				@(negedge mclk);
				chk("rx_data", 11'h097, 11'(rx_data));
				chk("rx_full", 11'h001, 11'(status.rx_full));
				chk("irq", 11'h001, 11'(irq));
				chk("frame_err", 11'h000, 11'(status.frame_err));
				chk("tx_empty", 11'h001, 11'(status.tx_empty));
				peer.send({1'b0, 1'b0, 8'h41});
				@(negedge mclk);
				chk("overrun", 11'h001, 11'(status.overrun));
				chk("frame_err", 11'h001, 11'(status.frame_err));
				chk("rx_data", 11'h041, 11'(rx_data));
			end
		join
		wait_caps(2);
		chk("frame0", {1'b1, 1'b1, 8'hA7, 1'b0}, peer.cap_q[0]);
		chk("frame1", {1'b1, 1'b0, 8'h3C, 1'b0}, peer.cap_q[1]);
		repeat (BIT) @(negedge mclk);
		chk("tx_done", 11'h001, 11'(status.tx_done));
		irq_en = 5'h00;
		@(negedge mclk);
		chk("irq_masked", 11'h000, 11'(irq));
		irq_en = 5'h02;
		@(negedge mclk);
		chk("irq_tx_done", 11'h001, 11'(irq));
		stat_clr = 8'hFF;
		rx_read = 1'b1;
		@(negedge mclk);
		stat_clr = 8'h00;
		rx_read = 1'b0;
		@(negedge mclk);
		chk("status_clr", 11'h000, 11'(status));
		chk("irq_clr", 11'h000, 11'(irq));
		// Nine bits with parity fall back to eight bits; a break arrives meanwhile
		set_cfg(1'b1, asp_pkg::ASP_PAR_ODD);
		tx_run = 1'b1;
		rx_run = 1'b1;
		irq_en = 5'h10;
		fork
			put(8'h5A, 1'b0);
			begin
				peer.hold_low(10 * BIT + 300);
				@(negedge mclk);
				chk("line_break", 11'h001, 11'(status.line_break));
				chk("irq_break", 11'h001, 11'(irq));
				// The all-low frame ends on a high stop with a wrong odd parity bit
				repeat (BIT) @(negedge mclk);
				chk("par_err", 11'h001, 11'(status.frame_err));
			end
		join
		wait_caps(3);
		chk("frame2", {1'b1, 1'b1, 8'h5A, 1'b0}, peer.cap_q[2]);
		// Stopped transmitter holds its word for 400 cycles while a nine-bit word starts arriving
		set_cfg(1'b1, asp_pkg::ASP_PAR_NONE);
		rx_run = 1'b1;
		fork
			begin
				put(8'hC3, 1'b0);
				repeat (400) begin
					@(negedge mclk);
					if (txd !== 1'b1) low = 1'b1;
				end
				chk("tx_held", 11'h000, 11'(low));
				tx_run = 1'b1;
			end
			begin
				peer.send({1'b1, 1'b1, 8'h6B});
				@(negedge mclk);
				chk("ninth", 11'h001, 11'(status.ninth));
				chk("rx_nine", 11'h06B, 11'(rx_data));
				chk("noise_err", 11'h000, 11'(status.noise_err));
			end
		join
		wait_caps(4);
		chk("frame3", {1'b1, 1'b0, 8'hC3, 1'b0}, peer.cap_q[3]);
		conclude();
	end
endmodule
